// ==== hdl/sar_seq_pkg.sv ====
// Constants for the conversion handshake and mux sequencer
package sar_seq_pkg;
  localparam int CLK_MHZ           = 25;
  localparam int T_BUSY_RISE_NS    = 40;
  localparam int T_CONV_NS         = 650;
  localparam int T_ACQ_NS          = 320;
  localparam int T_ABORT_MIN_NS    = 70;
  localparam int T_ABORT_MAX_NS    = 550;
  localparam int T_SETTLE_NS       = 600;
  // Longest times round down, least times round up
  localparam int CONV_CYCLES       = (T_CONV_NS * CLK_MHZ) / 1000;
  localparam int ABORT_MIN_CYCLES  = (T_ABORT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int ABORT_MAX_CYCLES  = (T_ABORT_MAX_NS * CLK_MHZ) / 1000;
  localparam int CNT_W             = 6;
  localparam int CHAN_W            = 2;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 2'h0;
  typedef enum logic [1:0] {CONV_IDLE, CONV_BUSY} conv_state_t;
endpackage

// ==== hdl/mux_sequencer.sv ====
// Channel sequencer for the input multiplexer
`timescale 1ns/1ns
`default_nettype none
module mux_sequencer (
  input  wire logic                            clk_sys,
  input  wire logic                            arst_n,
  input  wire logic                            clk_en,
  input  wire logic                            step,
  input  wire logic                            auto_scan,
  input  wire logic                            chan_select_lo,
  input  wire logic                            chan_select_hi,
  input  wire logic                            sequence_reset_select,
  output logic [sar_seq_pkg::CHAN_W-1:0]       chan_ff
);
  logic [sar_seq_pkg::CHAN_W-1:0] sel_code;
  logic [sar_seq_pkg::CHAN_W-1:0] nxt_chan;

  assign sel_code = {chan_select_hi, chan_select_lo};

  always_comb begin
    nxt_chan = chan_ff;
    if (auto_scan) begin
      if (sequence_reset_select) begin
        nxt_chan = sar_seq_pkg::CHAN_RESET;
      end else if (chan_ff >= sel_code) begin
        // wrap to zero; range from zero
        nxt_chan = sar_seq_pkg::CHAN_RESET;
      end else begin
        nxt_chan = chan_ff + 2'h1;
      end
    end else begin
      nxt_chan = sel_code;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chan_ff <= sar_seq_pkg::CHAN_RESET;
    end else if (clk_en && step) begin
      chan_ff <= nxt_chan;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/sar_conversion_mux_sequencer.sv ====
// Conversion handshake and multiplexer sequencer top
// Function
// - Start edge samples input and raises busy within 40 ns; the code raises busy two to three clocks (80-120 ns) after the fall.
// - Busy stays high at most 650 ns; result valid once busy low.
// - Second start with select low, or select fall, 70-550 ns aborts.
// - Channel changes only on a step clock rising edge.
// - Scan mode high selects auto-scan.
// - Auto-scan starts at channel zero; selects give last channel.
// - Step with sequence reset low moves to next channel.
// - Step after last channel wraps to zero.
// - Step with sequence reset high forces channel zero.
// - Scan mode low selects manual mode.
// - Manual step connects addressed channel; sequence reset ignored.
`timescale 1ns/1ns
`default_nettype none
module sar_conversion_mux_sequencer #(
  parameter int CONV_CYCLES = sar_seq_pkg::CONV_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  input  wire logic                      convert_start_n,
  input  wire logic                      chip_select_n,
  input  wire logic                      mux_step_clock,
  input  wire logic                      auto_scan,
  input  wire logic                      chan_select_lo,
  input  wire logic                      chan_select_hi,
  input  wire logic                      sequence_reset_select,
  output logic                           busy_ff,
  output logic                           sample_ff,
  output logic                           done_ff,
  output logic                           abort_ff,
  output logic [sar_seq_pkg::CHAN_W-1:0] conv_chan_ff,
  output logic [sar_seq_pkg::CHAN_W-1:0] chan_ff
);
  // Two-flop synchronisers, stage one read only by stage two
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [1:0] prev_ff;
  logic       cs_prev_ff;
  logic       start_fall;
  logic       cs_fall;
  logic       step_rise;
  logic [sar_seq_pkg::CNT_W-1:0] cnt_ff;
  sar_seq_pkg::conv_state_t      state_ff;
  logic                          abort_hit;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 6'h3F;
      sync2_ff <= 6'h3F;
    end else if (clk_en) begin
      sync1_ff <= {sequence_reset_select, chan_select_hi, chan_select_lo,
                   mux_step_clock, chip_select_n, convert_start_n};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff <= 2'h3;
    end else if (clk_en) begin
      prev_ff <= {sync2_ff[2], sync2_ff[0]};
    end
  end

  // Step reset value is high, so no edge is seen out of reset
  logic step_prev_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      step_prev_ff <= 1'b1;
    end else if (clk_en) begin
      step_prev_ff <= sync2_ff[2];
    end
  end

  assign start_fall = prev_ff[0] & ~sync2_ff[0];
  assign cs_fall    = cs_prev_ff & ~sync2_ff[1];
  assign step_rise  = ~step_prev_ff & sync2_ff[2];

  // Select edge detector; a fall seen out of reset lands in idle and is ignored
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev_ff <= 1'b1;
    end else if (clk_en) begin
      cs_prev_ff <= sync2_ff[1];
    end
  end

  assign abort_hit = (state_ff == sar_seq_pkg::CONV_BUSY)
                   && (cnt_ff >= sar_seq_pkg::CNT_W'(sar_seq_pkg::ABORT_MIN_CYCLES))
                   && (cnt_ff <= sar_seq_pkg::CNT_W'(sar_seq_pkg::ABORT_MAX_CYCLES))
                   && ((start_fall && !sync2_ff[1]) || cs_fall);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= sar_seq_pkg::CONV_IDLE;
      cnt_ff   <= '0;
      busy_ff  <= 1'b0;
      sample_ff <= 1'b0;
      done_ff  <= 1'b0;
      abort_ff <= 1'b0;
    end else if (clk_en) begin
      sample_ff <= 1'b0;
      done_ff   <= 1'b0;
      abort_ff  <= 1'b0;
      case (state_ff)
        sar_seq_pkg::CONV_IDLE: begin
          if (start_fall) begin
            state_ff  <= sar_seq_pkg::CONV_BUSY;
            busy_ff   <= 1'b1;
            sample_ff <= 1'b1;
            cnt_ff    <= '0;
          end
        end
        sar_seq_pkg::CONV_BUSY: begin
          cnt_ff <= cnt_ff + 6'h01;
          if (abort_hit) begin
            state_ff <= sar_seq_pkg::CONV_IDLE;
            busy_ff  <= 1'b0;
            abort_ff <= 1'b1;
          end else if (cnt_ff >= sar_seq_pkg::CNT_W'(CONV_CYCLES - 1)) begin
            state_ff <= sar_seq_pkg::CONV_IDLE;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b1;
          end
        end
        default: begin
          state_ff <= sar_seq_pkg::CONV_IDLE;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end

  // Channel latched at sampling time, tagging the result
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      conv_chan_ff <= sar_seq_pkg::CHAN_RESET;
    end else if (clk_en && start_fall && state_ff == sar_seq_pkg::CONV_IDLE) begin
      conv_chan_ff <= chan_ff;
    end
  end

  // sequencer steps on synchronised rising edge
  mux_sequencer u_seq (
    .clk_sys               (clk_sys),
    .arst_n                (arst_n),
    .clk_en                (clk_en),
    .step                  (step_rise),
    .auto_scan             (auto_scan),
    .chan_select_lo        (sync2_ff[3]),
    .chan_select_hi        (sync2_ff[4]),
    .sequence_reset_select (sync2_ff[5]),
    .chan_ff               (chan_ff)
  );
endmodule
`default_nettype wire

// ==== tb/sar_seq_asserts.sv ====
// Checker for busy handshake and channel stepping
`timescale 1ns/1ns
`default_nettype none
module sar_seq_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic convert_start_n,
  input wire logic mux_step_clock,
  input wire logic auto_scan,
  input wire logic chan_select_lo,
  input wire logic chan_select_hi,
  input wire logic sequence_reset_select,
  input wire logic busy_ff,
  input wire logic sample_ff,
  input wire logic done_ff,
  input wire logic abort_ff,
  input wire logic [sar_seq_pkg::CHAN_W-1:0] chan_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic [1:0] sel = {chan_select_hi, chan_select_lo};
  busy_rise_a: assert property (
    $fell(convert_start_n) && !busy_ff |-> ##[1:4] busy_ff && sample_ff) else $error("busy late");
  busy_len_a: assert property (
    $rose(busy_ff) |-> ##[1:16] !busy_ff) else $error("busy too long");
  conv_done_a: assert property (
    done_ff |-> !busy_ff && $past(busy_ff) && !abort_ff) else $error("stray done");
  abort_end_a: assert property (
    abort_ff |-> !busy_ff && $past(busy_ff)) else $error("stray abort");
  chan_step_a: assert property (
    $changed(chan_ff) |-> $past(mux_step_clock, 2) && !$past(mux_step_clock, 5)) else $error("chan no step");
  manual_a: assert property (
    $changed(chan_ff) && !auto_scan |-> chan_ff == sel) else $error("manual chan");
  auto_inc_a: assert property (
    $changed(chan_ff) && auto_scan && !sequence_reset_select && $past(chan_ff) != sel
    |-> chan_ff == $past(chan_ff) + 2'h1) else $error("auto step");
  auto_zero_a: assert property (
    $changed(chan_ff) && auto_scan && (sequence_reset_select || $past(chan_ff) == sel)
    |-> chan_ff == 2'h0) else $error("auto wrap");
endmodule
bind sar_conversion_mux_sequencer sar_seq_asserts sar_seq_asserts_inst (.*);
`default_nettype wire

// ==== tb/host_model.sv ====
// Host controller driving start, select and step pins
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_sys,
  output logic     convert_start_n,
  output logic     chip_select_n,
  output logic     mux_step_clock
);
  initial begin
    convert_start_n = 1'b1;
    chip_select_n = 1'b0;
    mux_step_clock = 1'b0;
  end
  // abort kinds: 1 start, 2 select
  task automatic convert(input int kind);
    @(posedge clk_sys) convert_start_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    convert_start_n <= 1'b1;
    if (kind != 0) begin
      if (kind == 2) chip_select_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      if (kind == 1) convert_start_n <= 1'b0;
      else chip_select_n <= 1'b0;
      @(posedge clk_sys) convert_start_n <= 1'b1;
    end
    repeat (30) @(posedge clk_sys);
  endtask
  task automatic step();
    @(posedge clk_sys) mux_step_clock <= 1'b1;
    repeat (5) @(posedge clk_sys);
    mux_step_clock <= 1'b0;
    repeat (16) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== tb/test_sar_conversion_mux_sequencer.sv ====
// Bench for conversion handshake and mux sequencer
`timescale 1ns/1ns
`default_nettype none
module test_sar_conversion_mux_sequencer;
  logic clk_sys, arst_n, auto_scan, chan_select_lo, chan_select_hi, sequence_reset_select;
  wire logic convert_start_n, chip_select_n, mux_step_clock, busy_ff, sample_ff, done_ff, abort_ff;
  wire logic [sar_seq_pkg::CHAN_W-1:0] conv_chan_ff, chan_ff;
  int err_total, checked, cyc, n_done, n_abort, run, last_run;
  host_model host_model_inst (.clk_sys(clk_sys), .convert_start_n(convert_start_n),
    .chip_select_n(chip_select_n), .mux_step_clock(mux_step_clock));
  sar_conversion_mux_sequencer sar_conversion_mux_sequencer_inst (.*, .clk_en(1'b1));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_done <= n_done + int'(done_ff);
    n_abort <= n_abort + int'(abort_ff);
    run <= busy_ff ? run + 1 : 0;
    if (busy_ff) last_run <= run + 1;
    if (cyc == 1000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic conv(input int kind, input int dn, input int ab);
    int d0, a0;
    d0 = n_done;
    a0 = n_abort;
    host_model_inst.convert(kind);
    chk("done count", n_done - d0, dn);
    chk("abort count", n_abort - a0, ab);
  endtask
  initial begin
    {arst_n, auto_scan, chan_select_lo, chan_select_hi, sequence_reset_select} = 5'h00;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    conv(0, 1, 0);
    chk("busy cycles", last_run, 16);
    conv(1, 0, 1);
    conv(2, 0, 1);
    $display("test conversion done");
    for (int ch = 0; ch < 4; ch++) begin
      {chan_select_hi, chan_select_lo} <= ch[1:0];
      sequence_reset_select <= ch[0];
      host_model_inst.step();
      chk("manual chan", chan_ff, ch);
    end
    conv(0, 1, 0);
    chk("sampled chan", conv_chan_ff, 3);
    $display("test manual done");
    auto_scan <= 1'b1;
    {chan_select_hi, chan_select_lo, sequence_reset_select} <= 3'h5;
    host_model_inst.step();
    chk("auto reset", chan_ff, 0);
    sequence_reset_select <= 1'b0;
    for (int i = 1; i < 5; i++) begin
      host_model_inst.step();
      chk("auto chan", chan_ff, i % 3);
    end
    sequence_reset_select <= 1'b1;
    host_model_inst.step();
    chk("mid reset", chan_ff, 0);
    $display("test auto done");
    close_out();
  end
endmodule
`default_nettype wire
